/* File: rtl/lps_core.sv */
// digital core of the light and proximity sensor: sequencer, converters, interrupt
//
// Summary of operation
// (RULE_01) broadband and infrared channels integrate together into 16-bit results
// (RULE_02) at end of conversion both results move into their data registers
// (RULE_03) interrupt leaves on its own pin as a level, never a pulse
// (RULE_04) asserted interrupt holds until the host clears it
// (RULE_05) result above upper or below lower threshold marks an interrupt condition
// (RULE_06) interrupt fires only after persistence-count consecutive out-of-window results
// (RULE_07) light and proximity keep own thresholds and persistence, judged separately
// (RULE_08) proximity pulse count per measurement programmable from 1 to 255
// (RULE_09) proximity led pulses repeat every sixteen microseconds
// (RULE_10) host talks over two-wire i2c at up to 400 kHz
// (RULE_11) wait timer between cycles from 2.72 ms to beyond six seconds
// (RULE_12) state machine sequences measurements and sleeps or waits between them
// (RULE_13) led driver is on for eight microseconds of each pulse period
// (RULE_14) each step adds at most 1023 counts, result saturates at 65535
// (RULE_15) host clears a pending interrupt with a clear command after reading results
module lps_core #(
    parameter int STEP_CYCLES = lps_pkg::STEP_CYC
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          arst_n,
    // enables
    input  wire logic                          power_on,
    input  wire logic                          als_enable,
    input  wire logic                          prox_enable,
    input  wire logic                          wait_enable,
    input  wire logic                          als_int_enable,
    input  wire logic                          prox_int_enable,
    // timing configuration
    input  wire logic [7:0]                    als_steps_m1,
    input  wire logic [7:0]                    wait_steps_m1,
    input  wire logic                          wait_long,
    input  wire logic [7:0]                    prox_pulses,
    // thresholds and persistence
    input  wire logic [15:0]                   als_low,
    input  wire logic [15:0]                   als_high,
    input  wire logic [15:0]                   prox_low,
    input  wire logic [15:0]                   prox_high,
    input  wire logic [3:0]                    als_persist,
    input  wire logic [3:0]                    prox_persist,
    // analog front end samples
    input  wire logic [lps_pkg::SAMPLE_W-1:0]  broadband_sample,
    input  wire logic [lps_pkg::SAMPLE_W-1:0]  infrared_sample,
    input  wire logic [lps_pkg::SAMPLE_W-1:0]  prox_sample,
    // i2c pins
    input  wire logic                          scl_i,
    input  wire logic                          sda_i,
    output logic                               sda_o,
    output logic                               sda_oe,
    // led driver and interrupt pins, open drain
    output logic                               led_driver_output_o,
    output logic                               led_driver_output_oe,
    output logic                               int_pad_o,
    output logic                               int_pad_oe,
    // results and status
    output logic [15:0]                        broadband_channel_data,
    output logic [15:0]                        infrared_channel_data,
    output logic [15:0]                        proximity_data,
    output logic                               als_valid,
    output logic                               prox_valid,
    output logic                               als_int_flag,
    output logic                               prox_int_flag,
    output logic                               low_power
);

    localparam int CMAX = (STEP_CYCLES > lps_pkg::LED_PERIOD_CYC) ? STEP_CYCLES : lps_pkg::LED_PERIOD_CYC;
    localparam int CW   = $clog2(CMAX + 1);

    typedef enum {S_SLEEP, S_PROX, S_ALS, S_WAIT} lps_seq_type;

    typedef struct packed {
        lps_seq_type st;
        logic [CW-1:0] cyc;
        logic [11:0]   steps;
        logic [7:0]    pulses;
        logic [16:0]   acc_bb;
        logic [16:0]   acc_ir;
        logic [16:0]   acc_px;
        logic [15:0]   bb_data;
        logic [15:0]   ir_data;
        logic [15:0]   px_data;
        logic          als_valid;
        logic          prox_valid;
        logic [3:0]    als_pcnt;
        logic [3:0]    prox_pcnt;
        logic          als_flag;
        logic          prox_flag;
        logic          led_oe;
        logic          int_oe;
        logic          pin_low;
        logic          low_pwr;
    } lps_core_state_type;

    lps_core_state_type cur_ff;
    lps_core_state_type nxt_ff;

    logic clear_pulse;

    // ==========================================================
    // serial link
    lps_i2c_slave u_i2c (
        .sys_clk     (sys_clk),
        .arst_n      (arst_n),
        .scl_i       (scl_i),                  // RULE_10
        .sda_i       (sda_i),
        .sda_o       (sda_o),
        .sda_oe      (sda_oe),
        .bb_data     (cur_ff.bb_data),
        .ir_data     (cur_ff.ir_data),
        .px_data     (cur_ff.px_data),
        .clear_pulse (clear_pulse)
    );

    // ==========================================================
    // helpers

    // clip one step to 1023 and add with saturation at 65535
    function automatic logic [16:0] sat_add(input logic [16:0] acc, input logic [11:0] smp);
        logic [11:0] c;
        logic [17:0] s;
        c = (smp > lps_pkg::STEP_MAX) ? lps_pkg::STEP_MAX : smp;             // RULE_14
        s = {1'b0, acc} + {6'h00, c};
        return (s > {1'b0, lps_pkg::FULL_SCALE}) ? lps_pkg::FULL_SCALE : s[16:0]; // RULE_14
    endfunction

    // window check with persistence: returns {hit, new count}
    function automatic logic [4:0] persist(input logic [15:0] r, input logic [15:0] lo,
                                           input logic [15:0] hi, input logic [3:0] need,
                                           input logic [3:0] cnt);
        logic       out_w;
        logic [4:0] inc;
        out_w = (r < lo) || (r > hi);                                        // RULE_05
        inc   = {1'b0, cnt} + 5'h01;
        if (!out_w) begin
            persist = {1'b0, lps_pkg::PCNT_RST};                             // RULE_06
        end else begin
            persist = {(inc >= {1'b0, need}), (cnt == 4'hF) ? cnt : inc[3:0]}; // RULE_06
        end
    endfunction

    logic [11:0] wait_total;
    logic [4:0]  als_eval;
    logic [4:0]  prox_eval;
    logic        step_end;
    logic        period_end;

    // ==========================================================
    // measurement sequencer
    always_comb begin
        nxt_ff     = cur_ff;
        wait_total = wait_long ? (({4'h0, wait_steps_m1} + 12'h001) * 12'(lps_pkg::WAIT_LONG_MULT))
                               : ({4'h0, wait_steps_m1} + 12'h001);          // RULE_11
        step_end   = (cur_ff.cyc == CW'(STEP_CYCLES - 1));
        period_end = (cur_ff.cyc == CW'(lps_pkg::LED_PERIOD_CYC - 1));        // RULE_09
        als_eval   = persist(cur_ff.acc_bb[15:0], als_low, als_high, als_persist, cur_ff.als_pcnt);
        prox_eval  = persist(cur_ff.acc_px[15:0], prox_low, prox_high, prox_persist, cur_ff.prox_pcnt);
        nxt_ff.als_flag  = cur_ff.als_flag & ~clear_pulse;                   // RULE_04
        nxt_ff.prox_flag = cur_ff.prox_flag & ~clear_pulse;                  // RULE_04
        unique case (cur_ff.st)
            S_SLEEP: begin
                nxt_ff.cyc    = '0;
                nxt_ff.steps  = 12'h000;
                nxt_ff.pulses = 8'h00;
                nxt_ff.acc_px = 17'h00000;
                nxt_ff.acc_bb = 17'h00000;
                nxt_ff.acc_ir = 17'h00000;
                if (power_on && prox_enable) begin
                    nxt_ff.st = S_PROX;                                      // RULE_12
                end else if (power_on && als_enable) begin
                    nxt_ff.st = S_ALS;
                end
            end
            S_PROX: begin
                nxt_ff.cyc = period_end ? '0 : cur_ff.cyc + CW'(1);
                if (period_end) begin
                    nxt_ff.acc_px = sat_add(cur_ff.acc_px, prox_sample);
                    prox_eval     = persist(nxt_ff.acc_px[15:0], prox_low, prox_high, prox_persist, cur_ff.prox_pcnt);
                    nxt_ff.pulses = cur_ff.pulses + 8'h01;
                    if (cur_ff.pulses + 8'h01 >= prox_pulses) begin         // RULE_08
                        nxt_ff.px_data    = nxt_ff.acc_px[15:0];
                        nxt_ff.prox_valid = 1'b1;
                        nxt_ff.prox_pcnt  = prox_eval[3:0];
                        if (prox_eval[4]) begin
                            nxt_ff.prox_flag = 1'b1;                         // RULE_07
                        end
                        nxt_ff.st = als_enable ? S_ALS : (wait_enable ? S_WAIT : S_SLEEP);
                    end
                end
                if (!power_on) begin
                    nxt_ff.st = S_SLEEP;
                end
            end
            S_ALS: begin
                nxt_ff.cyc = step_end ? '0 : cur_ff.cyc + CW'(1);
                if (step_end) begin
                    nxt_ff.acc_bb = sat_add(cur_ff.acc_bb, broadband_sample); // RULE_01
                    nxt_ff.acc_ir = sat_add(cur_ff.acc_ir, infrared_sample);  // RULE_01
                    nxt_ff.steps  = cur_ff.steps + 12'h001;
                    if (cur_ff.steps >= {4'h0, als_steps_m1}) begin
                        nxt_ff.bb_data   = nxt_ff.acc_bb[15:0];              // RULE_02
                        nxt_ff.ir_data   = nxt_ff.acc_ir[15:0];              // RULE_02
                        nxt_ff.als_valid = 1'b1;
                        als_eval         = persist(nxt_ff.acc_bb[15:0], als_low, als_high,
                                                   als_persist, cur_ff.als_pcnt);
                        nxt_ff.als_pcnt  = als_eval[3:0];
                        if (als_eval[4]) begin
                            nxt_ff.als_flag = 1'b1;                          // RULE_07
                        end
                        nxt_ff.steps = 12'h000;
                        nxt_ff.st    = wait_enable ? S_WAIT : S_SLEEP;
                    end
                end
                if (!power_on) begin
                    nxt_ff.st = S_SLEEP;
                end
            end
            S_WAIT: begin
                nxt_ff.cyc = step_end ? '0 : cur_ff.cyc + CW'(1);
                if (step_end) begin
                    nxt_ff.steps = cur_ff.steps + 12'h001;
                    if (cur_ff.steps + 12'h001 >= wait_total) begin          // RULE_11
                        nxt_ff.st = S_SLEEP;
                    end
                end
                if (!power_on) begin
                    nxt_ff.st = S_SLEEP;
                end
            end
        endcase
        // led pulses low for the first half of each period
        nxt_ff.led_oe  = (nxt_ff.st == S_PROX) && (nxt_ff.cyc < CW'(lps_pkg::LED_ON_CYC)); // RULE_13
        // level interrupt from sticky flags gated by enables
        nxt_ff.int_oe  = (nxt_ff.als_flag & als_int_enable) | (nxt_ff.prox_flag & prox_int_enable); // RULE_03
        nxt_ff.pin_low = 1'b0;
        nxt_ff.low_pwr = (nxt_ff.st == S_SLEEP) || (nxt_ff.st == S_WAIT);    // RULE_12
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff         <= '0;
            cur_ff.st      <= S_SLEEP;
            cur_ff.low_pwr <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ==========================================================
    // outputs, all from the state register
    assign led_driver_output_o    = cur_ff.pin_low;
    assign led_driver_output_oe   = cur_ff.led_oe;
    assign int_pad_o              = cur_ff.pin_low;
    assign int_pad_oe             = cur_ff.int_oe;
    assign broadband_channel_data = cur_ff.bb_data;
    assign infrared_channel_data  = cur_ff.ir_data;
    assign proximity_data         = cur_ff.px_data;
    assign als_valid              = cur_ff.als_valid;
    assign prox_valid             = cur_ff.prox_valid;
    assign als_int_flag           = cur_ff.als_flag;
    assign prox_int_flag          = cur_ff.prox_flag;
    assign low_power              = cur_ff.low_pwr;

endmodule

/* File: rtl/lps_pkg.sv */
// shared constants of the light and proximity sensor core
package lps_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS   = 50;          // 20 MHz system clock
    localparam int LED_PERIOD_NS   = 16000;       // proximity pulse period, 16 us
    localparam int LED_ON_NS       = 8000;        // led driver on time, 8 us
    localparam int STEP_NS         = 2720000;     // integration and wait step, 2.72 ms
    localparam int LED_PERIOD_CYC  = (LED_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LED_ON_CYC      = (LED_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_CYC        = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_LONG_MULT  = 12;          // wait step multiplier in long mode
    localparam int I2C_MAX_KHZ     = 400;         // fastest serial clock supported

    // ==========================================================
    // data widths and limits
    localparam int RESULT_W        = 16;
    localparam int SAMPLE_W        = 12;
    localparam logic [16:0] FULL_SCALE = 17'h0FFFF;   // 65535
    localparam logic [11:0] STEP_MAX   = 12'h3FF;     // 1023 counts per step

    // ==========================================================
    // serial link
    localparam logic [6:0] I2C_ADDR    = 7'h2A;   // arbitrary value
    localparam logic [7:0] CLEAR_CMD   = 8'hC5;   // interrupt clear command byte
    localparam logic [2:0] RD_LAST_IDX = 3'h5;    // six readable result bytes

    // ==========================================================
    // reset values
    localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
    localparam logic [3:0]          PCNT_RST   = 4'h0;

endpackage

/* File: rtl/lps_i2c_slave.sv */
// i2c slave: result byte reads and interrupt clear command
module lps_i2c_slave (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // serial pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // readable results
    input  wire logic [15:0] bb_data,
    input  wire logic [15:0] ir_data,
    input  wire logic [15:0] px_data,
    // command strobe
    output logic             clear_pulse
);

    typedef enum {I_IDLE, I_ADDR, I_ACK, I_WRITE, I_READ, I_RACK} lps_i2c_st_type;

    typedef struct packed {
        lps_i2c_st_type st;
        logic           scl_m;
        logic           scl_s;
        logic           scl_d;
        logic           sda_m;
        logic           sda_s;
        logic           sda_d;
        logic [3:0]     bits;
        logic [7:0]     shreg;
        logic           rd;
        logic [2:0]     idx;
        logic           sda_o;
        logic           sda_oe;
        logic           clr;
    } lps_i2c_state_type;

    lps_i2c_state_type cur_ff;
    lps_i2c_state_type nxt_ff;

    // result byte picked by read index, low byte first
    function automatic logic [7:0] pick(input logic [2:0] i, input logic [15:0] a,
                                        input logic [15:0] b, input logic [15:0] c);
        logic [7:0] r;
        unique case (i)
            3'h0:    r = a[7:0];
            3'h1:    r = a[15:8];
            3'h2:    r = b[7:0];
            3'h3:    r = b[15:8];
            3'h4:    r = c[7:0];
            3'h5:    r = c[15:8];
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    logic       rise;
    logic       fall;
    logic       start_c;
    logic       stop_c;
    logic [7:0] rbyte;

    // bus decoding and byte sequencing
    always_comb begin
        nxt_ff       = cur_ff;
        nxt_ff.clr   = 1'b0;
        nxt_ff.scl_m = scl_i;                     // two-stage synchronisers
        nxt_ff.scl_s = cur_ff.scl_m;
        nxt_ff.scl_d = cur_ff.scl_s;
        nxt_ff.sda_m = sda_i;
        nxt_ff.sda_s = cur_ff.sda_m;
        nxt_ff.sda_d = cur_ff.sda_s;
        rise    = cur_ff.scl_s & ~cur_ff.scl_d;
        fall    = ~cur_ff.scl_s & cur_ff.scl_d;
        start_c = cur_ff.scl_s & cur_ff.scl_d & cur_ff.sda_d & ~cur_ff.sda_s;
        stop_c  = cur_ff.scl_s & cur_ff.scl_d & ~cur_ff.sda_d & cur_ff.sda_s;
        rbyte   = pick(cur_ff.idx, bb_data, ir_data, px_data);
        if (start_c) begin
            nxt_ff.st     = I_ADDR;
            nxt_ff.bits   = 4'h0;
            nxt_ff.sda_oe = 1'b0;
        end else if (stop_c) begin
            nxt_ff.st     = I_IDLE;
            nxt_ff.sda_oe = 1'b0;
        end else begin
            unique case (cur_ff.st)
                I_IDLE: begin
                    nxt_ff.sda_oe = 1'b0;
                end
                I_ADDR, I_WRITE: begin
                    if (rise) begin
                        nxt_ff.shreg = {cur_ff.shreg[6:0], cur_ff.sda_s};
                        nxt_ff.bits  = cur_ff.bits + 4'h1;
                    end else if (fall && cur_ff.bits == 4'h8) begin
                        if (cur_ff.st == I_WRITE) begin
                            nxt_ff.sda_oe = 1'b1;     // acknowledge command byte
                            nxt_ff.st     = I_ACK;
                            nxt_ff.rd     = 1'b0;
                            nxt_ff.clr    = (cur_ff.shreg == lps_pkg::CLEAR_CMD); // RULE_15
                        end else if (cur_ff.shreg[7:1] == lps_pkg::I2C_ADDR) begin
                            nxt_ff.sda_oe = 1'b1;     // acknowledge own address
                            nxt_ff.st     = I_ACK;
                            nxt_ff.rd     = cur_ff.shreg[0];
                            nxt_ff.idx    = 3'h0;
                        end else begin
                            nxt_ff.st = I_IDLE;
                        end
                    end
                end
                I_ACK: begin
                    if (fall) begin
                        nxt_ff.bits = 4'h0;
                        if (cur_ff.rd) begin
                            nxt_ff.shreg  = rbyte;
                            nxt_ff.sda_oe = ~rbyte[7];
                            nxt_ff.st     = I_READ;
                        end else begin
                            nxt_ff.sda_oe = 1'b0;
                            nxt_ff.st     = I_WRITE;
                        end
                    end
                end
                I_READ: begin
                    if (fall) begin
                        nxt_ff.bits = cur_ff.bits + 4'h1;
                        if (cur_ff.bits == 4'h7) begin
                            nxt_ff.sda_oe = 1'b0;     // release for master ack
                            nxt_ff.st     = I_RACK;
                        end else begin
                            nxt_ff.shreg  = {cur_ff.shreg[6:0], 1'b0};
                            nxt_ff.sda_oe = ~cur_ff.shreg[6];
                        end
                    end
                end
                I_RACK: begin
                    if (rise) begin
                        if (cur_ff.sda_s) begin
                            nxt_ff.st = I_IDLE;       // master nack ends the read
                        end else begin
                            nxt_ff.idx = (cur_ff.idx == lps_pkg::RD_LAST_IDX) ? 3'h0 : cur_ff.idx + 3'h1;
                        end
                    end else if (fall) begin
                        nxt_ff.bits   = 4'h0;
                        nxt_ff.shreg  = rbyte;
                        nxt_ff.sda_oe = ~rbyte[7];
                        nxt_ff.st     = I_READ;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_ff        <= '0;
            cur_ff.st     <= I_IDLE;
            cur_ff.scl_m  <= 1'b1;
            cur_ff.scl_s  <= 1'b1;
            cur_ff.scl_d  <= 1'b1;
            cur_ff.sda_m  <= 1'b1;
            cur_ff.sda_s  <= 1'b1;
            cur_ff.sda_d  <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign sda_o       = cur_ff.sda_o;     // open drain: always low when enabled
    assign sda_oe      = cur_ff.sda_oe;
    assign clear_pulse = cur_ff.clr;

endmodule

/* File: testbench/lps_core_chk.sv */
// assertion checker bound to the sensor core ports
module lps_core_chk (
    // clock, reset and configuration
    input wire logic        sys_clk, arst_n, power_on, als_int_enable, prox_int_enable,
    input wire logic [7:0]  prox_pulses,
    // pins and status
    input wire logic        sda_o, led_driver_output_o, led_driver_output_oe, int_pad_o, int_pad_oe,
    input wire logic        als_int_flag, prox_int_flag, low_power,
    input wire logic [15:0] proximity_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] on_ff, per_ff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // led high-time and rise-to-rise counters
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            on_ff  <= 9'h000;
            per_ff <= 9'h1FF;
        end else begin
            on_ff  <= led_driver_output_oe ? on_ff + 9'h001 : 9'h000;
            per_ff <= (led_driver_output_oe && on_ff == 9'h000) ? 9'h001 : per_ff + {8'h00, per_ff != 9'h1FF};
        end
    end
    sequence s_rise; led_driver_output_oe && on_ff == 9'h000; endsequence
    sequence s_fall; !led_driver_output_oe && on_ff != 9'h000 && $past(power_on); endsequence
    // ==========================================================
    // pin and flag relations
    a_led_on_time: assert property (s_fall |-> on_ff == 9'h0A0)
        else $error("led on time wrong");
    a_led_period: assert property (s_rise |-> per_ff >= 9'h140)
        else $error("led pulse period short");
    a_int_level: assert property ($stable({als_int_enable, prox_int_enable}) |-> int_pad_oe ==
        (als_int_flag && als_int_enable || prox_int_flag && prox_int_enable)) else $error("int pin level wrong");
    a_clear_both: assert property ($fell(prox_int_flag) |-> !als_int_flag)
        else $error("flags not cleared together");
    a_sleep_dark: assert property (low_power |-> !led_driver_output_oe)
        else $error("led on in low power");
    a_power_abort: assert property (!power_on [*3] |-> low_power && !led_driver_output_oe)
        else $error("no sleep after power off");
    a_open_drain: assert property (!sda_o && !led_driver_output_o && !int_pad_o)
        else $error("open drain pin driven high");
    a_prox_bound: assert property ($changed(proximity_data) |-> {6'h00, proximity_data} <=
        (prox_pulses == 8'h00 ? 22'h000001 : {14'h0000, prox_pulses}) * 22'h0003FF) else $error("prox over limit");
endmodule

bind lps_core lps_core_chk u_chk (.*);

/* File: testbench/lps_i2c_host.sv */
// i2c host model driving the serial pins of the core
module lps_i2c_host (
    // serial pins
    input  wire logic sda_oe,
    output logic      scl_i,
    output logic      sda_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic m_low = 1'b0;
    initial scl_i = 1'b1;
    assign sda_i = !(m_low || sda_oe); // wired low with pull-up
    // one bit in a 400 ns scl period, sampled in the high phase
    task automatic bitx(input logic b, output logic r);
        m_low = !b;
        #100 scl_i = 1'b1;
        #100 r = sda_i;
        #100 scl_i = 1'b0;
        #100;
    endtask
    // one byte then the acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(last, a);
        ack = !a;
    endtask
    task automatic start;
        m_low = 1'b1;
        #200 scl_i = 1'b0;
    endtask
    task automatic stop;
        m_low = 1'b1;
        #100 scl_i = 1'b1;
        #100 m_low = 1'b0;
        #200;
    endtask
endmodule

/* File: testbench/lps_core_tb.sv */
// self-checking bench of the light and proximity sensor core
module lps_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, arst_n = 1'b0, power_on = 1'b0, als_enable = 1'b0, prox_enable = 1'b0;
    logic wait_enable = 1'b0, als_int_enable = 1'b0, prox_int_enable = 1'b0, wait_long = 1'b0;
    logic [7:0] als_steps_m1 = 8'hFF, wait_steps_m1 = 8'h00, prox_pulses = 8'h03, q;
    logic [15:0] als_low = 16'h0000, als_high = 16'hFFFF, prox_low = 16'h0000, prox_high = 16'hFFFF;
    logic [3:0] als_persist = 4'h1, prox_persist = 4'h2;
    logic [11:0] broadband_sample = 12'hFFF, infrared_sample, prox_sample;
    logic scl_i, sda_i, sda_o, sda_oe, led_driver_output_o, led_driver_output_oe, int_pad_o, int_pad_oe, ack;
    logic als_valid, prox_valid, als_int_flag, prox_int_flag, low_power;
    logic [15:0] broadband_channel_data, infrared_channel_data, proximity_data, exp_ir, exp_px;
    int fails = 0, total_checks = 0, n;
    lps_core #(.STEP_CYCLES(40)) dut (.*);
    lps_i2c_host host (.sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));
    initial forever #25 sys_clk = !sys_clk;
    initial begin
        #(80000 * 50);
        fails++;
        results();
    end
    // clipped and saturated accumulation of k samples
    function automatic logic [15:0] acc(input logic [11:0] s, input int k);
        int v;
        v = (s > 12'h3FF ? 1023 : int'(s)) * k;
        return (v > 65535) ? 16'hFFFF : 16'(v);
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #5;
    endtask
    task automatic results;
        if (fails == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // measurement, persistence, clear and readback
    initial begin
        void'($urandom(32'hF838));
        infrared_sample = 12'($urandom);
        prox_sample = 12'($urandom_range(1, 4095));
        prox_pulses = 8'($urandom_range(2, 4));
        exp_px = acc(prox_sample, int'(prox_pulses));
        exp_ir = acc(infrared_sample, 256);
        prox_high = exp_px - 16'h0001;
        tick(12);
        arst_n = 1'b1;
        {power_on, prox_enable, als_enable, prox_int_enable, als_int_enable} = 5'h1F;
        for (n = 0; n < 3000 && prox_valid !== 1'b1; n++) tick(1);
        check("prox data", proximity_data, exp_px);
        check("early flag", {15'h0000, prox_int_flag}, 16'h0000);
        for (n = 0; n < 12000 && als_valid !== 1'b1; n++) tick(1);
        check("broadband", broadband_channel_data, 16'hFFFF);
        check("infrared", infrared_channel_data, exp_ir);
        check("als flag", {15'h0000, als_int_flag}, 16'h0000);
        for (n = 0; n < 12000 && prox_int_flag !== 1'b1; n++) tick(1);
        check("int pin", {15'h0000, int_pad_oe}, 16'h0001);
        host.start();
        host.xfer({lps_pkg::I2C_ADDR ^ 7'h01, 1'b0}, 1'b1, q, ack);
        host.stop();
        tick(4);
        check("foreign ack", {15'h0000, ack}, 16'h0000);
        check("held pin", {15'h0000, int_pad_oe}, 16'h0001);
        host.start();
        host.xfer({lps_pkg::I2C_ADDR, 1'b1}, 1'b1, q, ack);
        for (int k = 0; k < 6; k++) begin
            host.xfer(8'hFF, k == 5, q, ack);
            check("read byte", {8'h00, q}, {8'h00, 8'({exp_px, exp_ir, 16'hFFFF} >> (8 * k))});
        end
        host.stop();
        host.start();
        host.xfer({lps_pkg::I2C_ADDR, 1'b0}, 1'b1, q, ack);
        host.xfer(lps_pkg::CLEAR_CMD, 1'b1, q, ack);
        host.stop();
        tick(4);
        check("cleared pin", {15'h0000, int_pad_oe}, 16'h0000);
        power_on = 1'b0;
        tick(3);
        check("low power", {15'h0000, low_power}, 16'h0001);
        results();
    end
endmodule
